// file: hdl/eir_axil_slave.sv
// module: axi4-lite slave front end turning bus beats into register strobes
`timescale 1ns/1ns
`default_nettype none
module eir_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [eir_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [eir_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [eir_pkg::AXI_SW-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [eir_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [eir_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [eir_pkg::AXI_AW-1:0] wr_addr,
    output logic [eir_pkg::AXI_DW-1:0] wr_data,
    output logic [eir_pkg::AXI_SW-1:0] wr_strb,
    input wire logic wr_ok,
    output logic [eir_pkg::AXI_AW-1:0] rd_addr,
    input wire logic [eir_pkg::AXI_DW-1:0] rd_data,
    input wire logic rd_ok
);
    import eir_pkg::*;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] waddr;
        logic [AXI_DW-1:0] wdata;
        logic [AXI_SW-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic awready;
        logic wready;
        logic arready;
        logic rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } eir_axil_s;

    eir_axil_s r_ff;
    eir_axil_s nxt_r;

    assign wr_en = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;
    assign wr_addr = r_ff.waddr;
    assign wr_data = r_ff.wdata;
    assign wr_strb = r_ff.wstrb;
    assign rd_addr = s_axi_araddr;
    assign s_axi_awready = r_ff.awready;
    assign s_axi_wready = r_ff.wready;
    assign s_axi_bvalid = r_ff.bvalid;
    assign s_axi_bresp = r_ff.bresp;
    assign s_axi_arready = r_ff.arready;
    assign s_axi_rvalid = r_ff.rvalid;
    assign s_axi_rdata = r_ff.rdata;
    assign s_axi_rresp = r_ff.rresp;

    always_comb begin
        nxt_r = r_ff;
        if (s_axi_awvalid && r_ff.awready) begin
            nxt_r.aw_got = 1'b1;
            nxt_r.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_ff.wready) begin
            nxt_r.w_got = 1'b1;
            nxt_r.wdata = s_axi_wdata;
            nxt_r.wstrb = s_axi_wstrb;
        end
        if (wr_en) begin
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = wr_ok ? RESP_OKAY : RESP_DECERR;
        end else if (r_ff.bvalid && s_axi_bready) begin
            nxt_r.bvalid = 1'b0;
        end
        // readies are registered so the top sees them straight from flops
        nxt_r.awready = !nxt_r.aw_got && !nxt_r.bvalid;
        nxt_r.wready = !nxt_r.w_got && !nxt_r.bvalid;
        if (s_axi_arvalid && r_ff.arready) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata = rd_ok ? rd_data : RD_ZERO;
            nxt_r.rresp = rd_ok ? RESP_OKAY : RESP_DECERR;
        end else if (r_ff.rvalid && s_axi_rready) begin
            nxt_r.rvalid = 1'b0;
        end
        nxt_r.arready = !nxt_r.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end
endmodule : eir_axil_slave
`default_nettype wire

// file: hdl/eir_irq_port.sv
// module: endpoint interrupt request port with its host-side control registers
`timescale 1ns/1ns
`default_nettype none

// Contract
// RL1 - The application holds its interrupt request high until it sees the grant.
// RL2 - The grant is raised in a cycle where the request is high and marks the message as sent.
// RL3 - For a legacy request the select input picks assert (1) or deassert (0); msi ignores it.
// RL4 - For multi-vector msi the low vector bits, as many as the enable code gives, are used.
// RL5 - With a single msi vector enabled the vector input is ignored.
// RL6 - Legacy messages only ever name the first interrupt pin, code 00h.
// RL7 - The low eight bits of the msi message data are shown on an output at all times.
// RL8 - The multiple message enable output runs from 000b to 101b and gives the vector bit count.
// RL9 - With msi enabled only msi messages are sent; otherwise legacy or msi-x. Here msi-x is sent instead when msi-x is enabled too.
// RL10 - With msi-x enabled only msi-x messages are sent; otherwise legacy or msi.
// RL11 - The msi-x function mask output at 1 masks every vector, holding back msi-x grants.
// RL12 - The 5-bit message number input is copied into the capability message number field.
// RL13 - The application updates the message number when a new enable code makes it invalid.
// RL14 - With automatic status update off, the status bit follows the application status input.
// RL15 - Everything runs on the user clock edge and pending requests die during reset.
module eir_irq_port #(
    parameter int TX_LAT_CYC = eir_pkg::TX_LAT_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [eir_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [eir_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [eir_pkg::AXI_SW-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [eir_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [eir_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic interrupt_req,
    output logic interrupt_rdy,
    input wire logic intx_assert_sel,
    input wire logic [eir_pkg::VEC_W-1:0] msi_vector_in,
    output logic [eir_pkg::VEC_W-1:0] msi_data_low,
    output logic [eir_pkg::MME_W-1:0] mm_enable,
    output logic msi_enable,
    output logic msix_enable,
    output logic msix_func_mask,
    input wire logic [eir_pkg::MSGNUM_W-1:0] msgnum_in,
    output logic [eir_pkg::MSGNUM_W-1:0] cap_msgnum,
    input wire logic int_stat_in,
    output logic int_status,
    output logic msg_tx_valid,
    output var eir_pkg::eir_kind_e msg_tx_kind,
    output logic [eir_pkg::MDATA_W-1:0] msg_tx_data
);
    import eir_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] LAT_LOAD = CNT_W'(TX_LAT_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    typedef struct packed {
        logic msi_en;
        logic msix_en;
        logic msix_fm;
        logic [MME_W-1:0] mme;
        logic auto_dis;
        logic [MDATA_W-1:0] msi_data;
        logic [MSGNUM_W-1:0] msgnum;
        logic int_status;
        logic busy;
        logic [CNT_W-1:0] cnt;
        logic rdy;
        logic tx_valid;
        eir_kind_e tx_kind;
        logic [MDATA_W-1:0] tx_data;
        logic [GCNT_W-1:0] count;
    } eir_state_s;

    eir_state_s r_ff;
    eir_state_s nxt_r;

    logic wr_en;
    logic [AXI_AW-1:0] wr_addr;
    logic [AXI_DW-1:0] wr_data;
    logic [AXI_SW-1:0] wr_strb;
    logic wr_ok;
    logic [AXI_AW-1:0] rd_addr;
    logic [AXI_DW-1:0] rd_data;
    logic rd_ok;
    logic [MDATA_W-1:0] msi_word;
    logic blocked;
    eir_kind_e kind;

    // ----------------------------------------------------------------
    // bus front end and msi data builder
    // ----------------------------------------------------------------
    eir_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    eir_msi_former u_msi (
        .msg_data(r_ff.msi_data),
        .mm_code(r_ff.mme),
        .vector(msi_vector_in),
        .data_out(msi_word)
    );

    // ----------------------------------------------------------------
    // register write accept and read side
    // ----------------------------------------------------------------
    assign wr_ok = (wr_addr == REG_CTRL) || (wr_addr == REG_MSIDATA) ||
                   (wr_addr == REG_STATUS) || (wr_addr == REG_LASTMSG) ||
                   (wr_addr == REG_COUNT);

    always_comb begin
        rd_data = RD_ZERO;
        rd_ok = 1'b1;
        unique case (rd_addr)
            REG_CTRL: begin
                rd_data[CTRL_MSI_EN] = r_ff.msi_en;
                rd_data[CTRL_MSIX_EN] = r_ff.msix_en;
                rd_data[CTRL_MSIX_FM] = r_ff.msix_fm;
                rd_data[CTRL_MME_LSB +: MME_W] = r_ff.mme;
                rd_data[CTRL_AUTO_DIS] = r_ff.auto_dis;
            end
            REG_MSIDATA: rd_data[MDATA_W-1:0] = r_ff.msi_data;
            REG_STATUS: begin
                rd_data[STAT_INT] = r_ff.int_status;
                rd_data[STAT_BUSY] = r_ff.busy;
                rd_data[STAT_MSGNUM_LSB +: MSGNUM_W] = r_ff.msgnum;
            end
            REG_LASTMSG: begin
                rd_data[MDATA_W-1:0] = r_ff.tx_data;
                rd_data[LAST_KIND_LSB +: 2] = r_ff.tx_kind;
            end
            REG_COUNT: rd_data[GCNT_W-1:0] = r_ff.count;
            default: rd_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // request engine
    // ----------------------------------------------------------------
    // msi-x wins over msi if software enables both; the host should never do so
    assign kind = r_ff.msix_en ? KIND_MSIX : r_ff.msi_en ? KIND_MSI : // RL9 RL10
                  intx_assert_sel ? KIND_ASSERT : KIND_DEASSERT; // RL3
    assign blocked = r_ff.msix_en && r_ff.msix_fm; // RL11

    always_comb begin
        logic [AXI_DW-1:0] c;
        c = RD_ZERO;
        nxt_r = r_ff;
        nxt_r.rdy = 1'b0;
        nxt_r.tx_valid = 1'b0;
        if (wr_en && wr_addr == REG_CTRL) begin
            c[CTRL_MSI_EN] = r_ff.msi_en;
            c[CTRL_MSIX_EN] = r_ff.msix_en;
            c[CTRL_MSIX_FM] = r_ff.msix_fm;
            c[CTRL_MME_LSB +: MME_W] = r_ff.mme;
            c[CTRL_AUTO_DIS] = r_ff.auto_dis;
            c = wmerge(c, wr_data, wr_strb);
            nxt_r.msi_en = c[CTRL_MSI_EN];
            nxt_r.msix_en = c[CTRL_MSIX_EN];
            nxt_r.msix_fm = c[CTRL_MSIX_FM];
            // codes above the top legal one saturate instead of wrapping
            nxt_r.mme = (c[CTRL_MME_LSB +: MME_W] > MME_MAX) ? MME_MAX :
                        c[CTRL_MME_LSB +: MME_W]; // RL8
            nxt_r.auto_dis = c[CTRL_AUTO_DIS];
        end
        if (wr_en && wr_addr == REG_MSIDATA) begin
            c = wmerge({{(AXI_DW-MDATA_W){1'b0}}, r_ff.msi_data}, wr_data, wr_strb);
            nxt_r.msi_data = c[MDATA_W-1:0];
        end
        nxt_r.msgnum = msgnum_in; // RL12
        if (r_ff.auto_dis) begin
            nxt_r.int_status = int_stat_in; // RL14
        end
        if (r_ff.busy) begin
            if (!interrupt_req) begin
                // request dropped early: abandon it, nothing goes out
                nxt_r.busy = 1'b0;
            end else if (r_ff.cnt != CNT_ZERO) begin
                nxt_r.cnt = r_ff.cnt - 1'b1;
            end else if (!blocked) begin
                nxt_r.busy = 1'b0;
                nxt_r.rdy = 1'b1; // RL2
                nxt_r.tx_valid = 1'b1;
                nxt_r.tx_kind = kind;
                nxt_r.count = r_ff.count + 1'b1;
                if (kind == KIND_MSI || kind == KIND_MSIX) begin
                    nxt_r.tx_data = msi_word; // RL4 RL5
                end else begin
                    nxt_r.tx_data = INTA_CODE; // RL6
                    if (!r_ff.auto_dis) begin
                        nxt_r.int_status = (kind == KIND_ASSERT);
                    end
                end
            end
        end else if (interrupt_req && !r_ff.rdy && !blocked) begin
            // the grant cycle itself never restarts, so one request sends once
            nxt_r.busy = 1'b1;
            nxt_r.cnt = LAT_LOAD;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_ff <= '0; // RL15
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign interrupt_rdy = r_ff.rdy;
    assign msi_data_low = r_ff.msi_data[VEC_W-1:0]; // RL7
    assign mm_enable = r_ff.mme; // RL8
    assign msi_enable = r_ff.msi_en; // RL9
    assign msix_enable = r_ff.msix_en; // RL10
    assign msix_func_mask = r_ff.msix_fm; // RL11
    assign cap_msgnum = r_ff.msgnum; // RL12
    assign int_status = r_ff.int_status;
    assign msg_tx_valid = r_ff.tx_valid;
    assign msg_tx_kind = r_ff.tx_kind;
    assign msg_tx_data = r_ff.tx_data;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    localparam int LAT_CHK = TX_LAT_CYC + 1;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_start;
        interrupt_req && !r_ff.busy && !r_ff.rdy && !blocked;
    endsequence
    sequence s_legacy_grant;
        msg_tx_valid && (msg_tx_kind == KIND_ASSERT || msg_tx_kind == KIND_DEASSERT);
    endsequence

    a_grant_timely: assert property (s_start |-> ##[1:LAT_CHK] // RL2
        (interrupt_rdy || !interrupt_req || blocked))
        else $error("grant late after request");
    a_grant_not_early: assert property (s_start |=> !interrupt_rdy) // RL2
        else $error("grant came too early");
    a_grant_with_msg: assert property (interrupt_rdy |-> msg_tx_valid && interrupt_req) // RL2
        else $error("grant without message or request");
    a_legacy_select: assert property (s_legacy_grant |-> // RL3
        (msg_tx_kind == KIND_ASSERT) == $past(intx_assert_sel) && msg_tx_data == INTA_CODE)
        else $error("legacy kind or pin code wrong");
    a_vector_bits: assert property (msg_tx_valid && msg_tx_kind == KIND_MSI |-> // RL4
        (msg_tx_data[VEC_W-1:0] & vec_mask(mm_enable)) ==
        ($past(msi_vector_in) & vec_mask(mm_enable)))
        else $error("msi vector bits wrong");
    a_single_vector: assert property (msg_tx_valid && msg_tx_kind == KIND_MSI && // RL5
        mm_enable == MME_SINGLE |-> msg_tx_data == r_ff.msi_data)
        else $error("single vector msi altered");
    a_data_low: assert property (wr_en && wr_addr == REG_MSIDATA && wr_strb[0] |=> // RL7
        msi_data_low == $past(wr_data[VEC_W-1:0]))
        else $error("message data low bits stale");
    a_mme_range: assert property (mm_enable <= MME_MAX) // RL8
        else $error("enable code out of range");
    a_msi_only: assert property (msg_tx_valid && msi_enable && !msix_enable |-> // RL9
        msg_tx_kind == KIND_MSI)
        else $error("non msi sent while msi enabled");
    a_msix_only: assert property (msg_tx_valid && msix_enable |-> msg_tx_kind == KIND_MSIX) // RL10
        else $error("non msi-x sent while msi-x enabled");
    a_func_mask: assert property (msix_enable && msix_func_mask |=> !interrupt_rdy) // RL11
        else $error("grant while function masked");
    a_msgnum_copy: assert property (##1 cap_msgnum == $past(msgnum_in)) // RL12
        else $error("message number not copied");
    a_status_follow: assert property (r_ff.auto_dis |=> int_status == $past(int_stat_in)) // RL14
        else $error("status bit not following input");
    a_reset_clears: assert property (@(posedge aclk) disable iff (1'b0) // RL15
        !aresetn |=> !interrupt_rdy && !r_ff.busy && !msg_tx_valid)
        else $error("request survived reset");
endmodule : eir_irq_port
`default_nettype wire

// file: hdl/eir_msi_former.sv
// module: builds the message data word of an msi from vector and enable code
`timescale 1ns/1ns
`default_nettype none
module eir_msi_former (
    input wire logic [eir_pkg::MDATA_W-1:0] msg_data,
    input wire logic [eir_pkg::MME_W-1:0] mm_code,
    input wire logic [eir_pkg::VEC_W-1:0] vector,
    output logic [eir_pkg::MDATA_W-1:0] data_out
);
    import eir_pkg::*;
    logic [MDATA_W-1:0] mask;

    // single vector gives an empty mask, so the vector input drops out
    assign mask = {{(MDATA_W-VEC_W){1'b0}}, vec_mask(mm_code)}; // RL4 RL5
    assign data_out = (msg_data & ~mask) | ({{(MDATA_W-VEC_W){1'b0}}, vector} & mask); // RL4
endmodule : eir_msi_former
`default_nettype wire

// file: hdl/eir_pkg.sv
// package: constants, types and helpers of the endpoint interrupt request port
`default_nettype none
package eir_pkg;
    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int AXI_SW = AXI_DW / 8;
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_MSIDATA = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_LASTMSG = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_COUNT = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [AXI_DW-1:0] RD_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int CTRL_MSI_EN = 0;
    localparam int CTRL_MSIX_EN = 1;
    localparam int CTRL_MSIX_FM = 2;
    localparam int CTRL_MME_LSB = 4;
    localparam int CTRL_AUTO_DIS = 8;
    localparam int MME_W = 3;
    localparam logic [MME_W-1:0] MME_SINGLE = 3'h0;
    localparam logic [MME_W-1:0] MME_MAX = 3'h5;
    localparam int STAT_INT = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_MSGNUM_LSB = 8;
    localparam int LAST_KIND_LSB = 16;
    localparam int MSGNUM_W = 5;
    localparam int VEC_W = 8;
    localparam int MDATA_W = 16;
    localparam logic [MDATA_W-1:0] INTA_CODE = 16'h0000;

    // ----------------------------------------------------------------
    // timing and message kinds
    // ----------------------------------------------------------------
    localparam int TX_LAT_DEF = 4;
    localparam int CNT_W = 8;
    localparam int GCNT_W = 16;

    typedef enum logic [1:0] {KIND_ASSERT, KIND_DEASSERT, KIND_MSI, KIND_MSIX} eir_kind_e;

    // low vector bits the application may override for a given enable code
    function automatic logic [VEC_W-1:0] vec_mask(input logic [MME_W-1:0] mme);
        logic [VEC_W:0] full;
        full = (9'h001 << mme) - 9'h001;
        return full[VEC_W-1:0];
    endfunction : vec_mask

    function automatic logic [AXI_DW-1:0] wmerge(input logic [AXI_DW-1:0] old,
                                                 input logic [AXI_DW-1:0] nw,
                                                 input logic [AXI_SW-1:0] strb);
        logic [AXI_DW-1:0] res;
        res = old;
        for (int i = 0; i < AXI_SW; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction : wmerge
endpackage : eir_pkg
`default_nettype wire

// file: verif/eir_app_model.sv
// partner model: application logic that requests interrupt messages
`timescale 1ns/1ns
`default_nettype none
module eir_app_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic interrupt_rdy,
    output logic interrupt_req
);
    logic req_ff;
    // held until the grant edge; an early drop would abandon the message
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_ff <= 1'h0;
        end else if (interrupt_rdy) begin
            req_ff <= 1'h0;
        end else if (go) begin
            req_ff <= 1'h1;
        end
    end
    assign interrupt_req = req_ff;
endmodule : eir_app_model
`default_nettype wire

// file: verif/endpoint_interrupt_request_port_test.sv
// testbench: interrupt request port with register bus and application model
`timescale 1ns/1ns
`default_nettype none
module endpoint_interrupt_request_port_test;
    import eir_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [AXI_AW-1:0] s_axi_awaddr = 8'h00;
    logic [AXI_AW-1:0] s_axi_araddr = 8'h00;
    logic [AXI_DW-1:0] s_axi_wdata = 32'h0000_0000;
    logic [AXI_SW-1:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0;
    logic intx_assert_sel = 1'h0, int_stat_in = 1'h0;
    logic [VEC_W-1:0] msi_vector_in = 8'h00;
    logic [MSGNUM_W-1:0] msgnum_in = 5'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [AXI_DW-1:0] s_axi_rdata, rd;
    logic interrupt_req, interrupt_rdy, msi_enable, msix_enable, msix_func_mask;
    logic int_status, msg_tx_valid;
    logic [VEC_W-1:0] msi_data_low;
    logic [MME_W-1:0] mm_enable;
    logic [MSGNUM_W-1:0] cap_msgnum;
    logic [MDATA_W-1:0] msg_tx_data;
    eir_kind_e msg_tx_kind;
    int fails = 0;
    int compares = 0;

    always #10 aclk = ~aclk;

    eir_irq_port #(.TX_LAT_CYC(TX_LAT_DEF)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .interrupt_req, .interrupt_rdy, .intx_assert_sel, .msi_vector_in,
        .msi_data_low, .mm_enable, .msi_enable, .msix_enable, .msix_func_mask, .msgnum_in,
        .cap_msgnum, .int_stat_in, .int_status, .msg_tx_valid, .msg_tx_kind, .msg_tx_data);
    eir_app_model i_app (.aclk, .aresetn, .go, .interrupt_rdy, .interrupt_req);

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic expire(input int n);
        if (n >= 64) begin
            fails++;
            finish_test();
        end
    endtask : expire

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic aw_p, w_p;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        aw_p = 1'h1;
        w_p = 1'h1;
        n = 0;
        // pending flags: the readies read here still show the pre-edge value
        while ((aw_p || w_p) && n < 64) begin
            @(posedge aclk);
            aw_p = aw_p & ~s_axi_awready;
            w_p = w_p & ~s_axi_wready;
            s_axi_awvalid <= aw_p;
            s_axi_wvalid <= w_p;
            n++;
        end
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_bvalid !== 1'h1 && n < 64);
        chk(s_axi_bresp, RESP_OKAY);
        s_axi_bready <= 1'h0;
        expire(n);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_arready !== 1'h1 && n < 64);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_rvalid !== 1'h1 && n < 64);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
        expire(n);
    endtask : axi_rd

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (interrupt_rdy !== 1'h1 && n < 64);
        expire(n);
        chk(interrupt_req, 1'h1);
        chk(msg_tx_valid, 1'h1);
    endtask : wait_rdy

    task automatic irq(input logic sel, input logic [7:0] v);
        @(posedge aclk);
        go <= 1'h1;
        intx_assert_sel <= sel;
        msi_vector_in <= v;
        @(posedge aclk);
        go <= 1'h0;
        wait_rdy();
    endtask : irq

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        axi_wr(REG_CTRL, 32'h0000_0077, 4'hf);
        axi_rd(REG_CTRL);
        chk(rd, 32'h0000_0057);
        chk(mm_enable, MME_MAX);
        chk({msi_enable, msix_enable, msix_func_mask}, 3'h7);
        axi_rd(8'h20);
        chk(rr, RESP_DECERR);
        chk(rd, RD_ZERO);
    endtask : t_regs

    task automatic t_legacy();
        axi_wr(REG_CTRL, 32'h0000_0000, 4'hf);
        irq(1'h1, 8'hff);
        chk(msg_tx_kind, KIND_ASSERT);
        chk(msg_tx_data, INTA_CODE);
        repeat (2) @(posedge aclk);
        chk(int_status, 1'h1);
        irq(1'h0, 8'hff);
        chk(msg_tx_kind, KIND_DEASSERT);
        repeat (2) @(posedge aclk);
        chk(int_status, 1'h0);
    endtask : t_legacy

    task automatic t_msi();
        axi_wr(REG_MSIDATA, 32'h0000_5A30, 4'h3);
        axi_wr(REG_CTRL, 32'h0000_0021, 4'hf);
        msgnum_in <= 5'h03;
        chk(msi_data_low, 8'h30);
        irq(1'h1, 8'hff);
        chk(msg_tx_kind, KIND_MSI);
        chk(msg_tx_data, 16'h5A33);
        axi_wr(REG_CTRL, 32'h0000_0001, 4'hf);
        msgnum_in <= 5'h00;
        irq(1'h0, 8'hff);
        chk(msg_tx_data, 16'h5A30);
        chk(cap_msgnum, 5'h00);
    endtask : t_msi

    task automatic t_msix();
        axi_wr(REG_CTRL, 32'h0000_0006, 4'hf);
        @(posedge aclk);
        go <= 1'h1;
        @(posedge aclk);
        go <= 1'h0;
        repeat (TX_LAT_DEF + 8) begin
            @(posedge aclk);
            chk(interrupt_rdy, 1'h0);
        end
        // grant lands several edges after the write, past the b beat
        axi_wr(REG_CTRL, 32'h0000_0002, 4'hf);
        wait_rdy();
        chk(msg_tx_kind, KIND_MSIX);
    endtask : t_msix

    task automatic t_stat();
        @(posedge aclk);
        msgnum_in <= 5'h15;
        int_stat_in <= 1'h1;
        axi_wr(REG_CTRL, 32'h0000_0100, 4'hf);
        repeat (2) @(posedge aclk);
        chk(cap_msgnum, 5'h15);
        chk(int_status, 1'h1);
        axi_rd(REG_STATUS);
        chk(rd, 32'h0000_1501);
        int_stat_in <= 1'h0;
        repeat (3) @(posedge aclk);
        chk(int_status, 1'h0);
    endtask : t_stat

    initial begin
        repeat (8) @(posedge aclk);
        chk({mm_enable, msi_enable, msix_enable, int_status, interrupt_rdy}, 7'h00);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_legacy();
        t_msi();
        t_msix();
        t_stat();
        finish_test();
    end
endmodule : endpoint_interrupt_request_port_test
`default_nettype wire
